// >>> src/lcd_out_pkg.sv
package lcd_out_pkg;

  // ************************************************************
  // timing constants
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 8;
  localparam int unsigned PANEL_HALF_NS      = 96;
  localparam int unsigned PANEL_HALF_CYCLES  =
    (PANEL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH         = 8;
  localparam int unsigned CNT_W              = 11;
  localparam logic [3:0]  DIV_LAST           = 4'(PANEL_HALF_CYCLES - 1);
  localparam logic [10:0] CNT_ZERO           = 11'h000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } rgb565_type;

  typedef struct packed {
    logic       valid;
    rgb565_type pixel;
  } pixel_beat_type;

  typedef struct packed {
    logic [CNT_W-1:0] h_active;
    logic [CNT_W-1:0] h_total;
    logic [CNT_W-1:0] hsync_start;
    logic [CNT_W-1:0] hsync_width;
    logic [CNT_W-1:0] v_active;
    logic [CNT_W-1:0] v_total;
    logic [CNT_W-1:0] vsync_start;
    logic [CNT_W-1:0] vsync_width;
  } panel_timing_type;

  typedef enum logic [0:0] {
    DE_LEVEL = 1'b0,
    DE_PULSE = 1'b1
  } de_mode_type;

  typedef enum logic [0:0] {
    EDGE_RISE = 1'b0,
    EDGE_FALL = 1'b1
  } launch_edge_type;

endpackage

// >>> src/lcd_panel_output_path.sv

// ************************************************************
// pixel buffer
// ************************************************************
module pixel_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  // fill level
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // pointer and level update
  always_comb begin
    push    = in_valid_i && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    pop     = out_ready_i && (cnt_r != '0);
    wr_nxt  = push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1)) : wr_r;
    rd_nxt  = pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1)) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];
  assign count_o     = cnt_r;
endmodule

// ************************************************************
// panel output path
// ************************************************************
module lcd_panel_output_path
  import lcd_out_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // panel clock source
  input  wire logic             panel_clock_source_in_i,
  input  wire logic             ext_clock_select_i,
  // configuration
  input  wire panel_timing_type timing_i,
  input  wire logic             hsync_active_high_i,
  input  wire logic             vsync_active_high_i,
  input  wire logic             de_mode_pulse_i,
  input  wire logic             sync_fall_launch_i,
  input  wire logic             pixel_fall_launch_i,
  input  wire logic             layer_one_enable_i,
  input  wire logic             layer_two_enable_i,
  // read buses
  input  wire pixel_beat_type   video_fetch_bus_i,
  output logic                  video_fetch_ready_o,
  input  wire pixel_beat_type   layer_one_read_bus_i,
  output logic                  layer_one_ready_o,
  input  wire pixel_beat_type   layer_two_read_bus_i,
  output logic                  layer_two_ready_o,
  // panel pins
  output logic                  panel_pixel_clock_out_o,
  output logic                  panel_horizontal_sync_out_o,
  output logic                  panel_vertical_sync_out_o,
  output logic                  panel_data_enable_out_o,
  output rgb565_type            panel_pixel_bus_o,
  output logic                  panel_alternating_out_o,
  // status
  output logic                  underrun_o
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_r, rst_n;

  // two stage release of the asynchronous reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ************************************************************
  // panel clock source
  // ************************************************************
  logic       ext_meta_r, ext_sync_r;
  logic [3:0] div_r, div_nxt;
  logic       int_clk_r, int_clk_nxt;
  logic       src_prev_r, pclk_r;
  logic       src_level, rise_evt, fall_evt;

  // divider and edge finder on the chosen source
  always_comb begin
    div_nxt     = (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
    int_clk_nxt = (div_r == DIV_LAST) ? ~int_clk_r : int_clk_r;
    src_level   = ext_clock_select_i ? ext_sync_r : int_clk_r;
    rise_evt    = src_level && !src_prev_r;
    fall_evt    = !src_level && src_prev_r;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      div_r      <= 4'h0;
      int_clk_r  <= 1'b0;
      src_prev_r <= 1'b0;
      pclk_r     <= 1'b0;
    end else begin
      ext_meta_r <= panel_clock_source_in_i;
      ext_sync_r <= ext_meta_r;
      div_r      <= div_nxt;
      int_clk_r  <= int_clk_nxt;
      src_prev_r <= src_level;
      pclk_r     <= src_level;
    end
  end

  // ************************************************************
  // compositor and buffer
  // ************************************************************
  logic                      fetch_rdy_r, fetch_rdy_nxt;
  logic                      take;
  rgb565_type                stage_one, stage_two;
  logic                      fifo_out_valid, fifo_pop;
  rgb565_type                fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_cnt;
  logic [$clog2(FIFO_DEPTH):0] cnt_after;

  // all three streams move together, layers override the video
  always_comb begin
    take      = fetch_rdy_r && video_fetch_bus_i.valid &&
                layer_one_read_bus_i.valid && layer_two_read_bus_i.valid;
    stage_one = layer_one_enable_i ? layer_one_read_bus_i.pixel
                                   : video_fetch_bus_i.pixel;
    stage_two = layer_two_enable_i ? layer_two_read_bus_i.pixel
                                   : stage_one;
    cnt_after = fifo_cnt + ($clog2(FIFO_DEPTH)+1)'(take) -
                ($clog2(FIFO_DEPTH)+1)'(fifo_pop && fifo_out_valid);
    fetch_rdy_nxt = (cnt_after < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 1));
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fetch_rdy_r <= 1'b0;
    end else begin
      fetch_rdy_r <= fetch_rdy_nxt;
    end
  end

  pixel_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (take),
    .in_ready_o  (),
    .in_data_i   (stage_two),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data),
    .count_o     (fifo_cnt)
  );

  // ************************************************************
  // panel timing counters
  // ************************************************************
  logic [CNT_W-1:0] h_r, h_nxt, v_r, v_nxt;
  logic             alt_r, alt_nxt;
  logic             hs_raw, vs_raw, active, de_start;

  // position counters advance on each pixel clock rise
  always_comb begin
    h_nxt   = h_r;
    v_nxt   = v_r;
    alt_nxt = alt_r;
    if (rise_evt) begin
      if (h_r >= timing_i.h_total - 11'h001) begin
        h_nxt   = CNT_ZERO;
        alt_nxt = ~alt_r;
        v_nxt   = (v_r >= timing_i.v_total - 11'h001) ? CNT_ZERO : v_r + 11'h001;
      end else begin
        h_nxt = h_r + 11'h001;
      end
    end
    hs_raw   = (h_r >= timing_i.hsync_start) &&
               (h_r < timing_i.hsync_start + timing_i.hsync_width);
    vs_raw   = (v_r >= timing_i.vsync_start) &&
               (v_r < timing_i.vsync_start + timing_i.vsync_width);
    active   = (h_r < timing_i.h_active) && (v_r < timing_i.v_active);
    de_start = (h_r == CNT_ZERO) && (v_r < timing_i.v_active);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      h_r   <= CNT_ZERO;
      v_r   <= CNT_ZERO;
      alt_r <= 1'b0;
    end else begin
      h_r   <= h_nxt;
      v_r   <= v_nxt;
      alt_r <= alt_nxt;
    end
  end

  // ************************************************************
  // output launch
  // ************************************************************
  logic       hs_r, hs_nxt, vs_r, vs_nxt, de_r, de_nxt;
  logic       sync_evt, pix_evt, urun_r, urun_nxt;
  rgb565_type pix_r, pix_nxt;

  // syncs and pixels launch on their own chosen edge
  always_comb begin
    sync_evt = sync_fall_launch_i ? fall_evt : rise_evt;
    pix_evt  = pixel_fall_launch_i ? fall_evt : rise_evt;
    hs_nxt   = hs_r;
    vs_nxt   = vs_r;
    de_nxt   = de_r;
    pix_nxt  = pix_r;
    urun_nxt = 1'b0;
    fifo_pop = 1'b0;
    if (sync_evt) begin
      hs_nxt = hs_raw ~^ hsync_active_high_i;
      vs_nxt = vs_raw ~^ vsync_active_high_i;
      de_nxt = de_mode_pulse_i ? de_start : active;
    end
    if (pix_evt) begin
      if (active) begin
        fifo_pop = 1'b1;
        pix_nxt  = fifo_out_valid ? fifo_out_data : '0;
        urun_nxt = !fifo_out_valid;
      end else begin
        pix_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hs_r   <= 1'b0;
      vs_r   <= 1'b0;
      de_r   <= 1'b0;
      pix_r  <= '0;
      urun_r <= 1'b0;
    end else begin
      hs_r   <= hs_nxt;
      vs_r   <= vs_nxt;
      de_r   <= de_nxt;
      pix_r  <= pix_nxt;
      urun_r <= urun_nxt;
    end
  end

  // every output straight from a flip-flop
  assign panel_pixel_clock_out_o     = pclk_r;
  assign panel_horizontal_sync_out_o = hs_r;
  assign panel_vertical_sync_out_o   = vs_r;
  assign panel_data_enable_out_o     = de_r;
  assign panel_pixel_bus_o           = pix_r;
  assign panel_alternating_out_o     = alt_r;
  assign underrun_o                  = urun_r;
  assign video_fetch_ready_o         = fetch_rdy_r;
  assign layer_one_ready_o           = fetch_rdy_r;
  assign layer_two_ready_o           = fetch_rdy_r;
endmodule

// >>> tb/lcd_out_checker.sv
module lcd_out_checker
  import lcd_out_pkg::*;
(
  // clock, reset and configuration
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             panel_clock_source_in_i,
  input wire logic             ext_clock_select_i,
  input wire panel_timing_type timing_i,
  input wire logic             hsync_active_high_i,
  input wire logic             de_mode_pulse_i,
  input wire logic             sync_fall_launch_i,
  input wire logic             pixel_fall_launch_i,
  // panel pins
  input wire logic             panel_pixel_clock_out_o,
  input wire logic             panel_horizontal_sync_out_o,
  input wire logic             panel_data_enable_out_o,
  input wire rgb565_type       panel_pixel_bus_o,
  input wire logic             panel_alternating_out_o,
  input wire logic             underrun_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // helper logic
  // ************************************************************
  logic        pclk, hs, de, ext, hact;
  logic [15:0] hcnt_r, hcnt_nxt;
  logic        live_r, live_nxt, pclk_r;
  // short aliases for the watched pins
  assign pclk = panel_pixel_clock_out_o;
  assign hs   = panel_horizontal_sync_out_o;
  assign de   = panel_data_enable_out_o;
  assign ext  = ext_clock_select_i;
  assign hact = hs == hsync_active_high_i;
  // length of active hsync; live once the pixel clock has fallen once
  always_comb begin
    hcnt_nxt = hact ? hcnt_r + 16'h0001 : 16'h0000;
    live_nxt = live_r | (pclk_r & !pclk);
  end
  // register helper state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {hcnt_r, live_r, pclk_r} <= '0;
    end else begin
      {hcnt_r, live_r, pclk_r} <= {hcnt_nxt, live_nxt, pclk};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_int_half: assert property (
    $rose(pclk) && !ext |-> ##12 $fell(pclk)) else $error("internal half period wrong");
  a_ext_follow: assert property (
    live_r && $rose(panel_clock_source_in_i) && ext |-> ##3 pclk) else $error("ext clock lag");
  a_hs_width: assert property (
    live_r && $fell(hact) && !ext |-> hcnt_r == 16'(timing_i.hsync_width) * 16'h0018)
    else $error("hsync width wrong");
  a_sync_edge: assert property (
    live_r && $changed(hs) |-> (sync_fall_launch_i ? $fell(pclk) : $rose(pclk)))
    else $error("sync launched on wrong edge");
  a_pixel_edge: assert property (
    live_r && $changed(panel_pixel_bus_o) |-> (pixel_fall_launch_i ? $fell(pclk) : $rose(pclk)))
    else $error("pixel launched on wrong edge");
  a_de_pulse: assert property (
    de_mode_pulse_i && $rose(de) && !ext |-> de [*8] ##17 !de) else $error("enable pulse length");
  a_alt_hold: assert property (
    live_r && $changed(panel_alternating_out_o) |=> $stable(panel_alternating_out_o) [*8])
    else $error("alternating output too fast");
  a_under_once: assert property (
    underrun_o |=> !underrun_o) else $error("underrun longer than one cycle");
  a_blank_black: assert property (
    !de_mode_pulse_i && sync_fall_launch_i == pixel_fall_launch_i && !de
    |-> panel_pixel_bus_o == 16'h0000) else $error("blank pixel not black");
  // main scenarios reached
  c_pulse: cover property (de_mode_pulse_i && $rose(de));
  c_under: cover property (underrun_o);
  c_ext: cover property (ext && $rose(pclk));
endmodule
bind lcd_panel_output_path lcd_out_checker i_chk (.clk_i, .rst_n_i, .panel_clock_source_in_i,
  .ext_clock_select_i, .timing_i, .hsync_active_high_i, .de_mode_pulse_i, .sync_fall_launch_i,
  .pixel_fall_launch_i, .panel_pixel_clock_out_o, .panel_horizontal_sync_out_o,
  .panel_data_enable_out_o, .panel_pixel_bus_o, .panel_alternating_out_o, .underrun_o);

// >>> tb/panel_model.sv
module panel_model
  import lcd_out_pkg::*;
(
  // dot clock, timing and data; no vertical sync taken
  input  wire logic       dot_clock_i,
  input  wire logic       sample_fall_i,
  input  wire logic       timing_in_i,
  input  wire rgb565_type pixel_i,
  // what the panel saw
  output int              pixels_o = 0,
  output int              lines_o = 0,
  output logic [5:0]      red6_o = 6'h00,
  output logic [5:0]      blue6_o = 6'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  logic de_q = 1'b0;
  // ************************************************************
  // sample away from the launch edge; rows come from the enable
  // ************************************************************
  always @(posedge dot_clock_i or negedge dot_clock_i) begin
    if (dot_clock_i != sample_fall_i) begin
      if (timing_in_i && !de_q) lines_o++;
      if (timing_in_i) begin
        pixels_o++;
        red6_o  = {pixel_i.red, pixel_i.red[0]};
        blue6_o = {pixel_i.blue, pixel_i.blue[0]};
      end
      de_q = timing_in_i;
    end
  end
endmodule

// >>> tb/testbench.sv
module testbench
  import lcd_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PP = 2 * PANEL_HALF_CYCLES;
  localparam int FR = 32 * PP;
  localparam logic [15:0] PIX [3] = '{16'hA815, 16'h5AA9, 16'hC7E3};
  logic             clk = 1'b0, src = 1'b0;
  logic             rst_n, ext, hpol, vpol, dmode, sfall, pfall, l1, l2;
  logic             rdy, pclk, hs, vs, de, alt, urun, alt_q = 1'b0;
  logic             rdy1, rdy2;
  panel_timing_type tm;
  pixel_beat_type   vbus, b1, b2;
  rgb565_type       px;
  int               fail_count = 0, n_compared = 0, pix, lin, nalt = 0, dp, dl, da;
  logic [5:0]       red6, blue6;
  // ************************************************************
  // clocks, design and panel
  // ************************************************************
  always #4 clk = !clk;
  initial begin
    #3;
    forever #80 src = !src;
  end
  // count toggles of the alternating output
  always @(posedge clk) begin
    nalt += int'(alt != alt_q);
    alt_q <= alt;
  end
  lcd_panel_output_path i_dut (.clk_i(clk), .rst_n_i(rst_n), .panel_clock_source_in_i(src),
    .ext_clock_select_i(ext), .timing_i(tm), .hsync_active_high_i(hpol),
    .vsync_active_high_i(vpol), .de_mode_pulse_i(dmode), .sync_fall_launch_i(sfall),
    .pixel_fall_launch_i(pfall), .layer_one_enable_i(l1), .layer_two_enable_i(l2),
    .video_fetch_bus_i(vbus), .video_fetch_ready_o(rdy), .layer_one_read_bus_i(b1),
    .layer_one_ready_o(rdy1), .layer_two_read_bus_i(b2), .layer_two_ready_o(rdy2),
    .panel_pixel_clock_out_o(pclk), .panel_horizontal_sync_out_o(hs),
    .panel_vertical_sync_out_o(vs), .panel_data_enable_out_o(de), .panel_pixel_bus_o(px),
    .panel_alternating_out_o(alt), .underrun_o(urun));
  panel_model i_panel (.dot_clock_i(pclk), .sample_fall_i(!pfall), .timing_in_i(de),
    .pixel_i(px), .pixels_o(pix), .lines_o(lin), .red6_o(red6), .blue6_o(blue6));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset with a new configuration, then wait three cycles plus the given warm-up
  task automatic setup(input logic [7:0] cfg, input logic [2:0] vld, input int warm);
    rst_n = 1'b0;
    {ext, hpol, vpol, dmode, sfall, pfall, l1, l2} = cfg;
    tm = {11'h004, 11'h008, 11'h005, 11'h002, 11'h002, 11'h004, 11'h002, 11'h001};
    vbus = {vld[0], PIX[0]};
    b1 = {vld[1], PIX[1]};
    b2 = {vld[2], PIX[2]};
    cyc(12);
    rst_n = 1'b1;
    cyc(3 + warm);
  endtask
  task automatic frame(input int len);
    int p0, l0, a0;
    {p0, l0, a0} = {pix, lin, nalt};
    cyc(len);
    {dp, dl, da} = {pix - p0, lin - l0, nalt - a0};
  endtask
  task automatic wait_for(input logic [1:0] sel);
    int k;
    for (k = 0; k < 2000 && (sel[0] ? urun : de) !== 1'b1; k++) cyc(1);
    if (k == 2000) begin
      fail_count++;
      complete_run();
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_layers();
    for (int i = 0; i < 3; i++) begin
      setup({6'b011000, i > 0, i > 1}, 3'b111, FR);
      frame(FR);
      check(16'(dp), 16'h0008);
      check(16'(dl), 16'h0002);
      check(16'(da), 16'h0004);
      check(16'(red6), 16'({PIX[i][15:11], PIX[i][11]}));
      check(16'(blue6), 16'({PIX[i][4:0], PIX[i][0]}));
      wait_for(2'b00);
      check(px, PIX[i]);
    end
  endtask
  task automatic t_pol();
    for (int i = 0; i < 4; i++) begin
      setup({1'b0, i[0], i[1], 1'b0, i[1], i[1], 2'b01}, 3'b111, FR);
      frame(FR);
      check(16'(dp), 16'h0008);
      wait_for(2'b00);
      check(16'(hs), 16'(!i[0]));
      check(16'(vs), 16'(!i[1]));
    end
  endtask
  task automatic t_pulse();
    setup(8'b01110000, 3'b111, FR);
    frame(FR);
    check(16'(dp), 16'h0002);
  endtask
  task automatic t_ext();
    setup(8'b11100001, 3'b111, 640);
    frame(640);
    check(16'(dp), 16'h0008);
    check(16'(dl), 16'h0002);
  endtask
  task automatic t_under();
    setup(8'b01100000, 3'b001, 0);
    wait_for(2'b01);
    check(px, 16'h0000);
    check(16'(rdy), 16'h0001);
    check(16'(rdy1), 16'h0001);
    check(16'(rdy2), 16'h0001);
  endtask
  initial begin
    t_layers();
    t_pol();
    t_pulse();
    t_ext();
    t_under();
    complete_run();
  end
endmodule
